/* src/sar_adc_regs.vh */
// constants for the successive-approximation converter sequencer
`ifndef SAR_ADC_REGS_VH
`define SAR_ADC_REGS_VH

// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MODE_ENABLE_BIT 7
`define MODE_SOURCE_BIT 6
`define MODE_TIME_HI 5
`define MODE_TIME_LO 3
`define MODE_EDGE_HI 2
`define MODE_EDGE_LO 1
`define MODE_REF_ON_BIT 0
`define MODE_RESET_VAL 8'h00
`define CHAN_RESET_VAL 3'h0

// ----------------------------------------
// trigger edge codes
// ----------------------------------------
`define EDGE_NONE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_RISE 2'h2
`define EDGE_BOTH 2'h3

// ----------------------------------------
// conversion time codes and clock counts
// ----------------------------------------
`define TIME_144 3'h0
`define TIME_120 3'h1
`define TIME_96 3'h2
`define TIME_288 3'h4
`define TIME_240 3'h5
`define TIME_192 3'h6
`define CLK_144 9'h090
`define CLK_120 9'h078
`define CLK_96 9'h060
`define CLK_288 9'h120
`define CLK_240 9'h0f0
`define CLK_192 9'h0c0
`define SAMPLE_SHARE 9'h008

`endif

/* src/trig_edge_detect.v */
// synchroniser and selectable edge detector for the external trigger pin
`include "sar_adc_regs.vh"
module trig_edge_detect
(
    input wire i_clk,
    input wire i_rst,
    input wire i_pin,
    input wire [1:0] i_edge_sel,
    output reg o_edge
);
    reg sync1_r;
    reg sync2_r;
    reg last_r;
    wire rise;
    wire fall;

    // ----------------------------------------
    // two-stage synchroniser, then edge compare
    // ----------------------------------------
    assign rise = sync2_r & ~last_r;
    assign fall = ~sync2_r & last_r;

    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r <= 1'b0;
            o_edge <= 1'b0;
        end
        else
        begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
            case (i_edge_sel)
                `EDGE_FALL: o_edge <= fall;
                `EDGE_RISE: o_edge <= rise;
                `EDGE_BOTH: o_edge <= rise | fall;
                default: o_edge <= 1'b0;
            endcase
        end
    end
endmodule

/* src/conv_timer.v */
// decodes the conversion time field into total clocks per conversion
`include "sar_adc_regs.vh"
module conv_timer
(
    input wire [2:0] i_time_sel,
    output reg [8:0] o_total,
    output reg o_legal
);
    // ----------------------------------------
    // time code decode
    // ----------------------------------------
    always @*
    begin
        o_legal = 1'b1;
        case (i_time_sel)
            `TIME_144: o_total = `CLK_144;
            `TIME_120: o_total = `CLK_120;
            `TIME_96: o_total = `CLK_96;
            `TIME_288: o_total = `CLK_288;
            `TIME_240: o_total = `CLK_240;
            `TIME_192: o_total = `CLK_192;
            default:
            begin
                // prohibited codes fall back to the longest time
                o_total = `CLK_288;
                o_legal = 1'b0;
            end
        endcase
    end
endmodule

/* src/sar_adc_sequencer.v */
// sequencer of an 8-bit successive-approximation converter
//
// What this block does
// - convert only the one channel named by the channel register
// - sample for a fixed time, then hold until conversion ends
// - start with top bit set, tap at half reference, keep if input >= tap
// - next bit tentative, tap from decided bits, keep if input >= tap
// - repeat set, compare, decide down to the least significant bit
// - after eight bits copy approximation to result and pulse done
// - first result after enabling with reference off is flagged invalid
// - converting continues until software clears the enable bit
// - mode or channel write aborts; restart from top bit if enabled
// - reset leaves the result register unset
// - result is rounded quantisation of input over reference
// - trigger mode with enable waits, then starts on a valid edge
// - trigger mode converts once per edge
// - trigger mode: enable rewrite mid-conversion aborts back to waiting
// - trigger mode: enable rewrite while waiting keeps waiting
// - mode write with enable clear stops conversion at once
// - software mode with enable converts back to back
// - software mode: enable rewrite restarts on the new channel
// - edge field: none, falling, rising, both
// - time field selects 144,120,96,288,240,192 clocks; others prohibited
// - register write at conversion end wins; no result, no done
// - reference circuit runs whenever conversion is enabled
`include "sar_adc_regs.vh"
module sar_adc_sequencer
(
    input wire I_SYS_CLK,
    input wire I_RST,
    input wire i_mode_wr,
    input wire [7:0] i_mode_wdata,
    input wire i_chan_wr,
    input wire [2:0] i_chan_wdata,
    input wire i_ext_trigger_pin,
    input wire i_comparator_ge,
    output reg [7:0] o_converter_mode_reg,
    output reg [2:0] o_channel_select_reg,
    output reg [7:0] o_analog_input_channels,
    output reg o_sample,
    output reg o_hold,
    output reg [7:0] o_tap_code,
    output reg [7:0] o_approximation_reg,
    output reg [7:0] o_conversion_result_reg,
    output reg o_result_valid,
    output reg o_conversion_done_irq,
    output reg o_reference_circuit_on,
    output reg o_busy,
    output reg o_time_prohibited
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_SAMPLE = 4'b0100;
    localparam ST_CONV = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [8:0] cnt_r;
    reg [8:0] cnt_nxt;
    reg [2:0] bit_r;
    reg [2:0] bit_nxt;
    reg [7:0] sar_nxt;
    reg first_bad_r;
    reg first_bad_nxt;
    reg finish;
    wire [7:0] mode_new;
    wire en_new;
    wire src_new;
    wire trig_edge;
    wire [8:0] total;
    wire legal;
    wire [8:0] step_len;
    wire [8:0] sample_len;
    wire reg_write;

    // one-hot decode, used for the channel mux enable and for the next tentative bit
    function [7:0] onehot8;
        input [2:0] idx;
        begin
            onehot8 = 8'h01 << idx;
        end
    endfunction

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    assign mode_new = i_mode_wr ? i_mode_wdata : o_converter_mode_reg;
    assign en_new = mode_new[`MODE_ENABLE_BIT];
    assign src_new = mode_new[`MODE_SOURCE_BIT];
    assign reg_write = i_mode_wr | i_chan_wr;
    // a bit step takes an equal share; remainder goes to sampling
    assign step_len = total >> 4;
    assign sample_len = total - {step_len[5:0], 3'h0};

    trig_edge_detect u_trig
    (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_pin(i_ext_trigger_pin),
        .i_edge_sel(o_converter_mode_reg[`MODE_EDGE_HI:`MODE_EDGE_LO]),
        .o_edge(trig_edge)
    );

    conv_timer u_timer
    (
        .i_time_sel(o_converter_mode_reg[`MODE_TIME_HI:`MODE_TIME_LO]),
        .o_total(total),
        .o_legal(legal)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always @*
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        sar_nxt = o_approximation_reg;
        first_bad_nxt = first_bad_r;
        finish = 1'b0;
        case (state_r)
            ST_IDLE:
            begin
                cnt_nxt = sample_len;
            end
            ST_WAIT:
            begin
                cnt_nxt = sample_len;
                if (trig_edge)
                    state_nxt = ST_SAMPLE;
            end
            ST_SAMPLE:
            begin
                if (cnt_r <= 9'h001)
                begin
                    state_nxt = ST_CONV;
                    cnt_nxt = step_len;
                    bit_nxt = 3'h7;
                    sar_nxt = 8'h80;
                end
                else
                    cnt_nxt = cnt_r - 9'h001;
            end
            ST_CONV:
            begin
                if (cnt_r <= 9'h001)
                begin
                    cnt_nxt = step_len;
                    // decide current bit, then set the next one tentatively
                    sar_nxt[bit_r] = i_comparator_ge;
                    if (bit_r == 3'h0)
                    begin
                        finish = 1'b1;
                        cnt_nxt = sample_len;
                        if (o_converter_mode_reg[`MODE_SOURCE_BIT])
                            state_nxt = ST_WAIT;
                        else
                            state_nxt = ST_SAMPLE;
                    end
                    else
                    begin
                        bit_nxt = bit_r - 3'h1;
                        sar_nxt = sar_nxt | onehot8(bit_r - 3'h1);
                    end
                end
                else
                    cnt_nxt = cnt_r - 9'h001;
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // register writes override the state, count and done pulse chosen above
        if (reg_write)
        begin
            finish = 1'b0;
            cnt_nxt = sample_len;
            if (!en_new)
                state_nxt = ST_IDLE;
            else if (src_new)
                state_nxt = ST_WAIT;
            else
                state_nxt = ST_SAMPLE;
        end
        if (i_mode_wr && en_new && !o_converter_mode_reg[`MODE_ENABLE_BIT])
            first_bad_nxt = ~i_mode_wdata[`MODE_REF_ON_BIT];
        if (finish)
            first_bad_nxt = 1'b0;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 9'h000;
            bit_r <= 3'h7;
            first_bad_r <= 1'b0;
            o_converter_mode_reg <= `MODE_RESET_VAL;
            o_channel_select_reg <= `CHAN_RESET_VAL;
            o_approximation_reg <= 8'h00;
            o_conversion_done_irq <= 1'b0;
            o_result_valid <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            first_bad_r <= first_bad_nxt;
            o_approximation_reg <= sar_nxt;
            if (i_mode_wr)
                o_converter_mode_reg <= i_mode_wdata;
            if (i_chan_wr)
                o_channel_select_reg <= i_chan_wdata;
            o_conversion_done_irq <= finish;
            if (finish)
                o_result_valid <= ~first_bad_r;
        end
    end

    // result has no reset: its content is unknown after reset
    always @(posedge I_SYS_CLK)
    begin
        if (finish)
            o_conversion_result_reg <= sar_nxt;
    end

    // ----------------------------------------
    // analog-side controls, registered
    // ----------------------------------------
    always @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            o_analog_input_channels <= 8'h00;
            o_sample <= 1'b0;
            o_hold <= 1'b0;
            o_tap_code <= 8'h80;
            o_reference_circuit_on <= 1'b0;
            o_busy <= 1'b0;
            o_time_prohibited <= 1'b0;
        end
        else
        begin
            o_analog_input_channels <= mode_new[`MODE_ENABLE_BIT] ?
                onehot8(i_chan_wr ? i_chan_wdata : o_channel_select_reg) :
                8'h00;
            o_sample <= (state_nxt == ST_SAMPLE);
            o_hold <= (state_nxt == ST_CONV);
            o_tap_code <= sar_nxt;
            o_reference_circuit_on <=
                mode_new[`MODE_REF_ON_BIT] | en_new;
            o_busy <= (state_nxt == ST_SAMPLE) | (state_nxt == ST_CONV);
            o_time_prohibited <= ~legal;
        end
    end
endmodule

/* test/analog_src.sv */
// analog sources and comparator model facing the sequencer
module analog_src
(
    input wire logic i_clk,
    input wire logic [71:0] i_levels,
    input wire logic [7:0] i_chan_onehot,
    input wire logic i_sample,
    input wire logic [7:0] i_tap,
    output logic o_ge
);
    timeunit 1ns;
    timeprecision 1ps;
    // levels are in half steps of the reference over 256
    logic [8:0] held_r;
    // ----------------------------------------
    // sample and hold
    // ----------------------------------------
    // only the sampled voltage reaches the comparator, so late moves are lost
    always @(posedge i_clk)
        for (int k = 0; k < 8; k++)
            if (i_sample && i_chan_onehot[k])
                held_r <= i_levels[k*9 +: 9];
    // the half step added here makes the code a rounded one
    assign o_ge = ({1'b0, held_r} + 10'h001) >= {1'b0, i_tap, 1'b0};
endmodule

/* test/sar_adc_sequencer_chk.sv */
// concurrent checks on the converter sequencer ports
module sar_adc_sequencer_chk
(
    input wire I_SYS_CLK,
    input wire I_RST,
    input wire i_mode_wr,
    input wire [7:0] i_mode_wdata,
    input wire i_chan_wr,
    input wire [7:0] o_converter_mode_reg,
    input wire [2:0] o_channel_select_reg,
    input wire [7:0] o_analog_input_channels,
    input wire o_sample,
    input wire o_hold,
    input wire [7:0] o_tap_code,
    input wire [7:0] o_approximation_reg,
    input wire o_conversion_done_irq,
    input wire o_reference_circuit_on,
    input wire o_busy,
    input wire o_time_prohibited
);
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_RST);
    property p_chan;
        o_hold |-> o_analog_input_channels == (8'h01 << o_channel_select_reg);
    endproperty
    a_chan: assert property (p_chan)
        else $error("wrong channel routed");
    property p_hold;
        $fell(o_sample) && !$past(i_mode_wr) && !$past(i_chan_wr) |-> o_hold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("sampling ended without hold");
    property p_msb;
        $rose(o_hold) |-> o_tap_code == 8'h80;
    endproperty
    a_msb: assert property (p_msb)
        else $error("first tap not half scale");
    property p_tap;
        o_hold |-> o_tap_code == o_approximation_reg;
    endproperty
    a_tap: assert property (p_tap)
        else $error("tap differs from approximation");
    property p_pulse;
        o_conversion_done_irq |=> !o_conversion_done_irq;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("done pulse too long");
    property p_wins;
        i_mode_wr || i_chan_wr |=> !o_conversion_done_irq;
    endproperty
    a_wins: assert property (p_wins)
        else $error("done raised after register write");
    property p_stop;
        i_mode_wr && !i_mode_wdata[7] |=> !o_busy;
    endproperty
    a_stop: assert property (p_stop)
        else $error("conversion not stopped");
    property p_ref;
        o_converter_mode_reg[7] && $past(o_converter_mode_reg[7])
            |-> o_reference_circuit_on;
    endproperty
    a_ref: assert property (p_ref)
        else $error("reference off while enabled");
    property p_prohib;
        $stable(o_converter_mode_reg[4:3])
            |-> o_time_prohibited == (o_converter_mode_reg[4:3] == 2'h3);
    endproperty
    a_prohib: assert property (p_prohib)
        else $error("prohibited time flag wrong");
    // a mode write in the same cycle may legally restart in software mode
    property p_noedge;
        o_converter_mode_reg[7:6] == 2'h3 && o_converter_mode_reg[2:1] == 2'h0
            && !i_mode_wr |=> !$rose(o_busy);
    endproperty
    a_noedge: assert property (p_noedge)
        else $error("start with edge detection off");
endmodule
bind sar_adc_sequencer sar_adc_sequencer_chk sar_adc_sequencer_chk_inst
(
    .I_SYS_CLK, .I_RST, .i_mode_wr, .i_mode_wdata, .i_chan_wr,
    .o_converter_mode_reg, .o_channel_select_reg, .o_analog_input_channels,
    .o_sample, .o_hold, .o_tap_code, .o_approximation_reg,
    .o_conversion_done_irq, .o_reference_circuit_on, .o_busy,
    .o_time_prohibited
);

/* test/sar_adc_sequencer_tb.sv */
// self-checking bench for the converter sequencer
module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic I_SYS_CLK, I_RST, i_mode_wr, i_chan_wr, i_ext_trigger_pin;
    logic [7:0] i_mode_wdata, o_converter_mode_reg, o_analog_input_channels;
    logic [7:0] o_tap_code, o_approximation_reg, o_conversion_result_reg, m;
    logic [2:0] i_chan_wdata, o_channel_select_reg, ch;
    logic i_comparator_ge, o_sample, o_hold, o_result_valid, o_busy;
    logic o_conversion_done_irq, o_reference_circuit_on, o_time_prohibited;
    logic [71:0] levels, old;
    logic [2:0] tc [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3};
    int tk [7] = '{144, 120, 96, 288, 240, 192, 288};
    int err_total = 0, samples_checked = 0, seed = 10407, n, c;
    sar_adc_sequencer sar_adc_sequencer_inst
    (
        .I_SYS_CLK, .I_RST, .i_mode_wr, .i_mode_wdata, .i_chan_wr,
        .i_chan_wdata, .i_ext_trigger_pin, .i_comparator_ge,
        .o_converter_mode_reg, .o_channel_select_reg, .o_analog_input_channels,
        .o_sample, .o_hold, .o_tap_code, .o_approximation_reg,
        .o_conversion_result_reg, .o_result_valid, .o_conversion_done_irq,
        .o_reference_circuit_on, .o_busy, .o_time_prohibited
    );
    analog_src analog_src_inst
    (
        .i_clk(I_SYS_CLK), .i_levels(levels),
        .i_chan_onehot(o_analog_input_channels),
        .i_sample(o_sample), .i_tap(o_tap_code), .o_ge(i_comparator_ge)
    );
    function automatic logic [7:0] code(input logic [71:0] lv,
        input logic [2:0] k);
        logic [8:0] v;
        v = lv[k*9 +: 9];
        code = (v == 9'h1ff) ? 8'hff : 8'((v + 9'h001) >> 1);
    endfunction
    task automatic check(input string what, input logic [8:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (err_total == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one-cycle write strobe, gap of a cycle before the next one
    task automatic wr(input bit md, input logic [7:0] v);
        @(posedge I_SYS_CLK);
        i_mode_wr <= md;
        i_chan_wr <= !md;
        i_mode_wdata <= v;
        i_chan_wdata <= v[2:0];
        @(posedge I_SYS_CLK);
        i_mode_wr <= 1'b0;
        i_chan_wr <= 1'b0;
    endtask
    task automatic wait_irq(output int k);
        k = 0;
        do
        begin
            @(negedge I_SYS_CLK);
            k++;
        end
        while (o_conversion_done_irq !== 1'b1 && k < 700);
        if (k >= 700)
            err_total++;
    endtask
    task automatic wait_hold;
        int k;
        for (k = 0; k < 400 && o_hold !== 1'b1; k++)
            @(negedge I_SYS_CLK);
        if (k >= 400)
            err_total++;
    endtask
    task automatic count_irq(input int cyc, output int k);
        k = 0;
        repeat (cyc)
        begin
            @(negedge I_SYS_CLK);
            k += (o_conversion_done_irq === 1'b1);
        end
    endtask
    initial
    begin
        I_SYS_CLK = 1'b0;
        forever #2.5 I_SYS_CLK = ~I_SYS_CLK;
    end
    // far above the longest expected run of about 6500 cycles
    initial
    begin
        #400000;
        err_total++;
        conclude;
    end
    initial
    begin
        {I_RST, i_mode_wr, i_chan_wr, i_ext_trigger_pin} = 4'h8;
        {i_mode_wdata, i_chan_wdata, levels} = '0;
        repeat (2) @(posedge I_SYS_CLK);
        I_RST <= 1'b0;
        // ----------------------------------------
        // software start over every legal time code and prohibited code 3
        // ----------------------------------------
        foreach (tc[i])
        begin
            ch = 3'($random(seed));
            levels = {$random(seed), $random(seed), 8'($random(seed))};
            wr(0, {5'h00, ch});
            wr(1, 8'h00);
            wr(1, {2'b10, tc[i], 2'b00, 1'(i)});
            wait_irq(n);
            check("valid first", o_result_valid, 9'(i % 2));
            check("prohibited", o_time_prohibited,
                tc[i][1:0] == 2'h3);
            wait_hold;
            old = levels;
            levels = ~levels;
            wait_irq(n);
            check("held result", o_conversion_result_reg,
                code(old, ch));
            check("valid later", o_result_valid, 1);
            wait_irq(n);
            check("period", (n - tk[i]) inside {0, 1}, 1);
            check("result", o_conversion_result_reg,
                code(levels, ch));
        end
        // ----------------------------------------
        // channel write aborts, then a stop
        // ----------------------------------------
        wr(1, 8'h91);
        wait_hold;
        ch = 3'($random(seed));
        wr(0, {5'h00, ch});
        wait_irq(n);
        check("restart", o_conversion_result_reg,
            code(levels, ch));
        wait_hold;
        wr(1, 8'h00);
        count_irq(400, c);
        check("stopped", c, 0);
        check("busy", o_busy, 0);
        // ----------------------------------------
        // trigger start for each edge code
        // ----------------------------------------
        for (int e = 0; e < 4; e++)
        begin
            m = {5'b11010, 2'(e), 1'b1};
            wr(1, m);
            count_irq(20, c);
            @(posedge I_SYS_CLK);
            i_ext_trigger_pin <= 1'b1;
            if (e == 3)
            begin
                count_irq(20, c);
                wr(1, m);
            end
            count_irq(200, c);
            check("rise start", c, e == 2);
            @(posedge I_SYS_CLK);
            i_ext_trigger_pin <= 1'b0;
            count_irq(200, c);
            check("fall start", c, e % 2);
        end
        conclude;
    end
endmodule
